// File: shared/fbsp_pkg.sv
// constants, register map and types of the flyback supervisor
package fbsp_pkg;
  localparam int CLK_HZ              = 125_000_000;
  localparam int STARTUP_TIMEOUT_MS  = 200;
  localparam int STARTUP_TIMEOUT_CYC = STARTUP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int NPROT               = 8;
  localparam int PA_W                = 12;
  // protection channel indices
  localparam int CH_PRIM_OC  = 0;
  localparam int CH_OUT_UV   = 1;
  localparam int CH_OUT_OV   = 2;
  localparam int CH_OUT_OC   = 3;
  localparam int CH_OUT_OP   = 4;
  localparam int CH_CS_SHORT = 5;
  localparam int CH_CCM      = 6;
  localparam int CH_BUS      = 7;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_FAULT     = 12'h008;
  localparam logic [11:0] ADDR_REACTION  = 12'h00C;
  localparam logic [11:0] ADDR_CS_CFG    = 12'h010;
  localparam logic [11:0] ADDR_START_CFG = 12'h014;
  localparam logic [11:0] ADDR_VOUT_CFG  = 12'h018;
  localparam logic [11:0] ADDR_LOAD_CFG  = 12'h01C;
  localparam logic [11:0] ADDR_START_V   = 12'h020;
  localparam logic [11:0] ADDR_SS_CFG    = 12'h024;
  localparam logic [11:0] ADDR_DEMAND    = 12'h028;
  localparam logic [11:0] ADDR_RESTART   = 12'h02C;
  localparam logic [11:0] ADDR_BLANK_LO  = 12'h040;
  localparam logic [11:0] ADDR_BLANK_HI  = 12'h04C;
  // field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int HALF_LO      = 0;
  localparam int HALF_HI      = 16;
  // reset values
  localparam logic [15:0] RST_OCP2     = 16'hFFFF;
  localparam logic [15:0] RST_FLOOR    = 16'h0100;
  localparam logic [15:0] RST_FINAL    = 16'h0800;
  localparam logic [15:0] RST_STEP     = 16'h0100;
  localparam logic [15:0] RST_UV       = 16'h0000;
  localparam logic [15:0] RST_OV       = 16'hFFFF;
  localparam logic [15:0] RST_OC       = 16'hFFFF;
  localparam logic [15:0] RST_OP       = 16'hFFFF;
  localparam logic [15:0] RST_VSTART   = 16'h0400;
  localparam logic [15:0] RST_BUSMIN   = 16'h0400;
  localparam logic [15:0] RST_SSTIME   = 16'h00FF;
  localparam logic [15:0] RST_BUSTOL   = 16'hFFFF;
  localparam logic [15:0] RST_BLANK    = 16'h0010;
  localparam logic [15:0] RST_BLANK_OV = 16'h0000;
  localparam logic [15:0] RST_DCM_EXT  = 16'hFFFF;
  localparam logic [15:0] RST_RESTART  = 16'hFFFF;
  localparam logic [7:0]  RST_REACTION = 8'h00;
  localparam logic [15:0] CS_SHORT_LEVEL = 16'h0010;
  localparam logic [15:0] DCM_EXT_MAX    = 16'hFFFF;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT_BUS = 3'b001,
    ST_SOFT     = 3'b010,
    ST_CHARGE   = 3'b011,
    ST_REGULATE = 3'b100,
    ST_FAULT    = 3'b101
  } fbsp_state_type;
endpackage : fbsp_pkg

// File: shared/fbsp_blank_if.sv
// carrier between the supervisor and one blanking qualifier
`timescale 1ns/1ps
`default_nettype none
interface fbsp_blank_if;
  logic        fault;
  logic [15:0] blank_time;
  logic        trigger;
  modport qual (input fault, input blank_time, output trigger);
  modport ctrl (output fault, output blank_time, input trigger);
endinterface : fbsp_blank_if
`default_nettype wire

// File: core/fbsp_blank.sv
// blanking qualifier for one protection channel
`timescale 1ns/1ps
`default_nettype none
module fbsp_blank (
  input  wire logic   pclk,
  input  wire logic   presetn,
  fbsp_blank_if.qual  bif
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        trig_q;
  logic        trig_d;

  always_comb
  begin
    cnt_d  = 16'h0000;
    trig_d = 1'b0;
    if (bif.fault)
    begin
      // saturate so a held fault never wraps back into blanking
      cnt_d  = (cnt_q == 16'hFFFF) ? cnt_q : cnt_q + 16'h0001; // see RULE21
      trig_d = trig_q | (cnt_q >= bif.blank_time); // see RULE7
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 16'h0000;
      trig_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      trig_q <= trig_d;
    end
  end

  assign bif.trigger = trig_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BLANK_TRIP: assert property ( // see RULE7
    (bif.fault && cnt_q == bif.blank_time) |=> trig_q)
    else $error("blanking did not trip at the set time");
  AST_BLANK_RESTART: assert property ( // see RULE21
    !bif.fault |=> (cnt_q == 16'h0000 && !trig_q))
    else $error("blanking count not restarted");
endmodule : fbsp_blank
`default_nettype wire

// File: core/fbsp_top.sv
// flyback mode, soft-start and protection supervisor with apb registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: quasi-resonant mode turns on at first valley, power set by peak limit
// RULE2: demand at the floor selects discontinuous mode with longer period
// RULE3: soft-start raises the current limit in steps held for set time
// RULE4: after final startup limit, keep charging until startup voltage
// RULE5: startup voltage reached enables ccm and undervoltage checks, loop
// RULE6: regulation begins discontinuous, longest period, shortest on-time
// RULE7: protections trip only after fault outlasts its blanking time
// RULE8: a tripped protection runs its own configured reaction
// RULE9: primary current above second threshold past blanking trips
// RULE10: output below undervoltage level past blanking trips, not in startup
// RULE11: startup not reaching startup voltage before timeout trips undervolt
// RULE12: output above overvoltage level past blanking trips
// RULE13: calculated output current above limit past blanking trips
// RULE14: calculated output power above limit past blanking trips
// RULE15: overvoltage blanking is set to its minimum by default
// RULE16: watchdog catches current-sense shorted to ground and trips
// RULE17: entering continuous conduction trips a protection
// RULE18: flyback waits until bus voltage is high enough
// RULE19: implausible bus voltage reading trips a protection
// RULE20: bus voltage from aux clamp is cross-checked with sensed bus
// RULE21: blanking count restarts whenever the fault clears early
module fbsp_top
  import fbsp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = STARTUP_TIMEOUT_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [PA_W-1:0]  paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             valley_pulse,
  input  wire logic             ccm_detect,
  input  wire logic [15:0]      flyback_current_sense_pin,
  input  wire logic [15:0]      vout_meas,
  input  wire logic [15:0]      iout_calc,
  input  wire logic [15:0]      pout_calc,
  input  wire logic [15:0]      bus_voltage_sense_pin,
  input  wire logic [15:0]      vbus_aux,
  output logic                  gate_drive,
  output logic      [15:0]      peak_current_limit,
  output logic                  first_valley_mode,
  output logic                  fault_active
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic        en_q, en_d;
  logic [7:0]  react_q, react_d, fault_q, fault_d;
  logic [15:0] ocp2_q, ocp2_d, floor_q, floor_d, final_q, final_d;
  logic [15:0] step_q, step_d, uv_q, uv_d, ov_q, ov_d, oc_q, oc_d;
  logic [15:0] op_q, op_d, vstart_q, vstart_d, busmin_q, busmin_d;
  logic [15:0] sstime_q, sstime_d, bustol_q, bustol_d;
  logic [15:0] demand_q, demand_d, dcmext_q, dcmext_d;
  logic [15:0] restart_q, restart_d;
  logic [15:0] blank_q [NPROT];
  logic [15:0] blank_d [NPROT];
  logic [31:0] prdata_q, prdata_d, rd_mux;
  logic        pready_q, pready_d, pslverr_q, pslverr_d, hit;
  logic        setup, wr;
  // sequencer state
  fbsp_state_type state_q, state_d;
  logic [15:0] limit_q, limit_d, ss_cnt_q, ss_cnt_d;
  logic [15:0] wait_q, wait_d, rst_cnt_q, rst_cnt_d;
  logic [TW-1:0] tmo_q, tmo_d;
  logic        gate_q, gate_d, qr_q, qr_d, waiting_q, waiting_d;
  // fault flag from its own flop, so the pin never shows a decode glitch
  logic        fault_act_q;
  logic        enter_reg, run, tmo_trip, latched;
  logic [16:0] ss_sum;
  logic [15:0] bus_diff;
  logic [NPROT-1:0] cond, trig, new_fault;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait state after the setup cycle
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready_q && pwrite;

  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == ADDR_CTRL)
      rd_mux = {31'h0000_0000, en_q};
    else if (paddr == ADDR_STATUS)
      rd_mux = {25'h000_0000, fault_active, qr_q, gate_q, 1'b0, state_q};
    else if (paddr == ADDR_FAULT)
      rd_mux = {24'h00_0000, fault_q};
    else if (paddr == ADDR_REACTION)
      rd_mux = {24'h00_0000, react_q};
    else if (paddr == ADDR_CS_CFG)
      rd_mux = {floor_q, ocp2_q};
    else if (paddr == ADDR_START_CFG)
      rd_mux = {step_q, final_q};
    else if (paddr == ADDR_VOUT_CFG)
      rd_mux = {ov_q, uv_q};
    else if (paddr == ADDR_LOAD_CFG)
      rd_mux = {op_q, oc_q};
    else if (paddr == ADDR_START_V)
      rd_mux = {busmin_q, vstart_q};
    else if (paddr == ADDR_SS_CFG)
      rd_mux = {bustol_q, sstime_q};
    else if (paddr == ADDR_DEMAND)
      rd_mux = {dcmext_q, demand_q};
    else if (paddr == ADDR_RESTART)
      rd_mux = {16'h0000, restart_q};
    else if (paddr >= ADDR_BLANK_LO && paddr <= ADDR_BLANK_HI
             && paddr[1:0] == 2'b00)
      rd_mux = {blank_q[{paddr[3:2], 1'b1}], blank_q[{paddr[3:2], 1'b0}]};
    else
      hit = 1'b0;
  end

  always_comb
  begin
    pready_d  = setup;
    prdata_d  = setup ? (pwrite ? 32'h0000_0000 : rd_mux) : prdata_q;
    pslverr_d = setup && !hit;
    en_d = en_q;          react_d = react_q;
    ocp2_d = ocp2_q;      floor_d = floor_q;    final_d = final_q;
    step_d = step_q;      uv_d = uv_q;          ov_d = ov_q;
    oc_d = oc_q;          op_d = op_q;          vstart_d = vstart_q;
    busmin_d = busmin_q;  sstime_d = sstime_q;  bustol_d = bustol_q;
    demand_d = demand_q;  dcmext_d = dcmext_q;  restart_d = restart_q;
    blank_d = blank_q;
    fault_d = fault_q;
    if (wr && hit)
    begin
      if (paddr == ADDR_CTRL)
        en_d = pwdata[CTRL_EN_BIT];
      else if (paddr == ADDR_FAULT)
        fault_d = fault_q & ~pwdata[7:0];
      else if (paddr == ADDR_REACTION)
        react_d = pwdata[7:0];
      else if (paddr == ADDR_CS_CFG)
        {floor_d, ocp2_d} = pwdata;
      else if (paddr == ADDR_START_CFG)
        {step_d, final_d} = pwdata;
      else if (paddr == ADDR_VOUT_CFG)
        {ov_d, uv_d} = pwdata;
      else if (paddr == ADDR_LOAD_CFG)
        {op_d, oc_d} = pwdata;
      else if (paddr == ADDR_START_V)
        {busmin_d, vstart_d} = pwdata;
      else if (paddr == ADDR_SS_CFG)
        {bustol_d, sstime_d} = pwdata;
      else if (paddr == ADDR_DEMAND)
        {dcmext_d, demand_d} = pwdata;
      else if (paddr == ADDR_RESTART)
        restart_d = pwdata[15:0];
      else if (paddr >= ADDR_BLANK_LO)
      begin
        blank_d[{paddr[3:2], 1'b0}] = pwdata[HALF_LO +: 16];
        blank_d[{paddr[3:2], 1'b1}] = pwdata[HALF_HI +: 16];
      end
    end
    // loop starts at the floor with the longest discontinuous period
    if (enter_reg)
    begin
      demand_d = floor_q; // see RULE6
      dcmext_d = DCM_EXT_MAX; // see RULE6
    end
    // a new trip beats a same-cycle clear
    fault_d = fault_d | new_fault;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000; pready_q <= 1'b0; pslverr_q <= 1'b0;
      en_q <= 1'b0;          react_q <= RST_REACTION; fault_q <= 8'h00;
      ocp2_q <= RST_OCP2;    floor_q <= RST_FLOOR;    final_q <= RST_FINAL;
      step_q <= RST_STEP;    uv_q <= RST_UV;          ov_q <= RST_OV;
      oc_q <= RST_OC;        op_q <= RST_OP;          vstart_q <= RST_VSTART;
      busmin_q <= RST_BUSMIN; sstime_q <= RST_SSTIME; bustol_q <= RST_BUSTOL;
      demand_q <= RST_FLOOR; dcmext_q <= RST_DCM_EXT; restart_q <= RST_RESTART;
      for (int i = 0; i < NPROT; i++)
        blank_q[i] <= (i == CH_OUT_OV) ? RST_BLANK_OV : RST_BLANK; // see RULE15
    end
    else
    begin
      prdata_q <= prdata_d; pready_q <= pready_d; pslverr_q <= pslverr_d;
      en_q <= en_d;          react_q <= react_d;      fault_q <= fault_d;
      ocp2_q <= ocp2_d;      floor_q <= floor_d;      final_q <= final_d;
      step_q <= step_d;      uv_q <= uv_d;            ov_q <= ov_d;
      oc_q <= oc_d;          op_q <= op_d;            vstart_q <= vstart_d;
      busmin_q <= busmin_d;  sstime_q <= sstime_d;    bustol_q <= bustol_d;
      demand_q <= demand_d;  dcmext_q <= dcmext_d;    restart_q <= restart_d;
      blank_q <= blank_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection conditions and blanking
  assign run = (state_q == ST_SOFT) || (state_q == ST_CHARGE)
               || (state_q == ST_REGULATE);
  assign bus_diff = (bus_voltage_sense_pin >= vbus_aux)
                    ? bus_voltage_sense_pin - vbus_aux
                    : vbus_aux - bus_voltage_sense_pin;

  always_comb
  begin
    cond = '0;
    cond[CH_PRIM_OC]  = run && (flyback_current_sense_pin > ocp2_q); // see RULE9
    cond[CH_OUT_UV]   = (state_q == ST_REGULATE) && (vout_meas < uv_q); // see RULE10
    cond[CH_OUT_OV]   = run && (vout_meas > ov_q); // see RULE12
    cond[CH_OUT_OC]   = run && (iout_calc > oc_q); // see RULE13
    cond[CH_OUT_OP]   = run && (pout_calc > op_q); // see RULE14
    // a shorted sense pin shows no current rise while the gate is on
    cond[CH_CS_SHORT] = gate_q && (flyback_current_sense_pin < CS_SHORT_LEVEL); // see RULE16
    cond[CH_CCM]      = (state_q == ST_REGULATE) && ccm_detect; // see RULE17
    cond[CH_BUS]      = run && ((bus_diff > bustol_q) // see RULE20
                        || (bus_voltage_sense_pin < busmin_q)); // see RULE19
  end

  genvar g;
  generate
    for (g = 0; g < NPROT; g++)
    begin : g_prot
      fbsp_blank_if u_if ();
      assign u_if.fault      = cond[g];
      assign u_if.blank_time = blank_q[g];
      assign trig[g]         = u_if.trigger;
      fbsp_blank u_blank (
        .pclk    (pclk),
        .presetn (presetn),
        .bif     (u_if)
      );
    end
  endgenerate

  assign tmo_trip = ((state_q == ST_SOFT) || (state_q == ST_CHARGE))
                    && (tmo_q == TMO_LAST);
  always_comb
  begin
    new_fault = trig;
    new_fault[CH_OUT_UV] = trig[CH_OUT_UV] | tmo_trip; // see RULE11
  end
  assign latched = |(react_q & fault_q);

  ////////////////////////////////////////////////////////////////////////////
  // startup sequencer and switching control
  assign ss_sum = {1'b0, limit_q} + {1'b0, step_q};

  always_comb
  begin
    state_d = state_q;   limit_d = limit_q;   ss_cnt_d = ss_cnt_q;
    wait_d = wait_q;     rst_cnt_d = rst_cnt_q;
    tmo_d = tmo_q;       gate_d = gate_q;     qr_d = qr_q;
    waiting_d = waiting_q;
    enter_reg = 1'b0;
    case (state_q)
      ST_IDLE:
        if (en_q)
          state_d = ST_WAIT_BUS;
      ST_WAIT_BUS:
        if (bus_voltage_sense_pin >= busmin_q) // see RULE18
        begin
          state_d  = ST_SOFT;
          limit_d  = step_q;
          ss_cnt_d = 16'h0000;
          tmo_d    = '0; // see RULE11
          gate_d   = 1'b1;
          qr_d     = 1'b1;
        end
      ST_SOFT:
      begin
        tmo_d    = tmo_q + 1'b1;
        ss_cnt_d = ss_cnt_q + 16'h0001;
        if (ss_cnt_q >= sstime_q) // see RULE3
        begin
          ss_cnt_d = 16'h0000;
          if (ss_sum >= {1'b0, final_q})
          begin
            limit_d = final_q;
            state_d = ST_CHARGE;
          end
          else
            limit_d = ss_sum[15:0]; // see RULE3
        end
      end
      ST_CHARGE:
      begin
        tmo_d = tmo_q + 1'b1;
        if (vout_meas >= vstart_q) // see RULE4
        begin
          state_d   = ST_REGULATE; // see RULE5
          enter_reg = 1'b1;
          limit_d   = floor_q; // see RULE6
          qr_d      = 1'b0; // see RULE6
          waiting_d = 1'b0;
        end
      end
      ST_REGULATE:
      begin
        qr_d    = demand_q > floor_q; // see RULE2
        limit_d = qr_d ? demand_q : floor_q; // see RULE1
      end
      ST_FAULT:
      begin
        rst_cnt_d = rst_cnt_q + 16'h0001;
        // latched reactions wait for software to clear their fault bits
        if (latched)
          rst_cnt_d = 16'h0000;
        else if (rst_cnt_q >= restart_q) // see RULE8
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    // switching: on at valley (in dcm regulation once the extension wait after it runs out), off when current reaches the limit
    if (run && state_d != ST_IDLE && !(state_q == ST_WAIT_BUS))
    begin
      if (gate_q)
        gate_d = flyback_current_sense_pin < limit_q;
      else if (qr_q || state_q != ST_REGULATE)
        gate_d = valley_pulse; // see RULE1
      else if (waiting_q)
      begin
        wait_d = wait_q + 16'h0001;
        if (wait_q >= dcmext_q) // see RULE2
        begin
          gate_d    = 1'b1;
          waiting_d = 1'b0;
        end
      end
      else if (valley_pulse)
      begin
        waiting_d = 1'b1;
        wait_d    = 16'h0000;
      end
    end
    if (|new_fault && state_q != ST_FAULT) // see RULE8
    begin
      state_d   = ST_FAULT;
      gate_d    = 1'b0;
      rst_cnt_d = 16'h0000;
    end
    if (!en_q)
    begin
      state_d = ST_IDLE;
      gate_d  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;  limit_q <= 16'h0000; ss_cnt_q <= 16'h0000;
      wait_q <= 16'h0000;  rst_cnt_q <= 16'h0000; tmo_q <= '0;
      gate_q <= 1'b0;      qr_q <= 1'b1;        waiting_q <= 1'b0;
      fault_act_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;  limit_q <= limit_d;  ss_cnt_q <= ss_cnt_d;
      wait_q <= wait_d;    rst_cnt_q <= rst_cnt_d; tmo_q <= tmo_d;
      gate_q <= gate_d;    qr_q <= qr_d;        waiting_q <= waiting_d;
      fault_act_q <= (state_d == ST_FAULT);
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign gate_drive         = gate_q;
  assign peak_current_limit = limit_q;
  assign first_valley_mode  = qr_q;
  assign fault_active       = fault_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_step_due;
    state_q == ST_SOFT && ss_cnt_q >= sstime_q && ss_sum < {1'b0, final_q}
      && new_fault == '0 && en_q;
  endsequence

  AST_QR_VALLEY: assert property ( // see RULE1
    (state_q == ST_REGULATE && qr_q && !gate_q && valley_pulse && en_q
     && new_fault == '0) |=> gate_q)
    else $error("no turn-on at first valley");
  AST_DCM_FLOOR: assert property ( // see RULE2
    (state_q == ST_REGULATE && demand_q <= floor_q && en_q
     && new_fault == '0) |=> (!qr_q && limit_q == $past(floor_q)))
    else $error("floor demand did not select discontinuous mode");
  AST_SS_STEP: assert property ( // see RULE3
    s_step_due |=> limit_q == $past(limit_q) + $past(step_q))
    else $error("soft-start step wrong");
  AST_CHARGE_EXIT: assert property ( // see RULE5
    (state_q == ST_CHARGE && vout_meas >= vstart_q && en_q
     && new_fault == '0) |=> state_q == ST_REGULATE)
    else $error("startup voltage did not hand over to loop");
  AST_REG_ENTRY: assert property ( // see RULE6
    $rose(state_q == ST_REGULATE) |-> (demand_q == $past(floor_q)
     && dcmext_q == DCM_EXT_MAX && !qr_q
     && limit_q == $past(floor_q)))
    else $error("loop did not start at floor and longest period");
  AST_UV_STARTUP: assert property ( // see RULE10
    (state_q == ST_SOFT || state_q == ST_CHARGE) |-> !cond[CH_OUT_UV])
    else $error("undervoltage level checked during startup");
  AST_TIMEOUT: assert property ( // see RULE11
    tmo_trip |=> (fault_q[CH_OUT_UV] && state_q != ST_CHARGE
     && state_q != ST_SOFT))
    else $error("startup timeout did not trip undervoltage");
  AST_TRIP_STOP: assert property ( // see RULE8
    (|trig && state_q != ST_FAULT) |=> (!gate_q ##1 !gate_q))
    else $error("gate kept switching after a trip");
  AST_BUS_WAIT: assert property ( // see RULE18
    (state_q == ST_WAIT_BUS && bus_voltage_sense_pin < busmin_q)
    |=> state_q != ST_SOFT)
    else $error("flyback started on a low bus");
endmodule : fbsp_top
`default_nettype wire

// File: test/fbsp_stage_model.sv
// flyback stage model: sense ramp, valley echo, output charge
`timescale 1ns/1ps
`default_nettype none
module fbsp_stage_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        gate_drive,
  input  wire logic [15:0] rate,
  output logic             valley_pulse,
  output logic      [15:0] flyback_current_sense_pin,
  output logic      [15:0] vout_meas
);
  logic       gate_q;
  logic [2:0] ring_q;
  // valley comes a few cycles after turn-off, as the ring-down does
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gate_q                    <= 1'b0;
      ring_q                    <= 3'h0;
      valley_pulse              <= 1'b0;
      flyback_current_sense_pin <= 16'h0;
      vout_meas                 <= 16'h0;
    end
    else
    begin
      gate_q       <= gate_drive;
      valley_pulse <= (ring_q == 3'h1);
      ring_q       <= (gate_q && !gate_drive) ? 3'h4 :
                      (ring_q != 3'h0) ? ring_q - 3'h1 : 3'h0;
      // no current with the switch off, so sense reads zero
      flyback_current_sense_pin <= gate_drive ?
                      flyback_current_sense_pin + 16'h0040 : 16'h0;
      // zero rate stands for a shorted load that pulls the output down
      if (rate == 16'h0)
        vout_meas <= 16'h0;
      else if (gate_q && !gate_drive)
        vout_meas <= vout_meas + rate;
    end
endmodule : fbsp_stage_model
`default_nettype wire

// File: test/test_flyback_mode_startup_protection.sv
// self-checking bench for the flyback supervisor
`timescale 1ns/1ps
`default_nettype none
module test_flyback_mode_startup_protection import fbsp_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        valley, gate_drive, fv_mode, fault_active, ccm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] sense, vout, iout, pout, vbus, rate, lim, prv;
  logic [15:0] rnd = 16'h14F7; // seed 5367
  logic [64:0] note_q[$];
  logic [64:0] nt;
  int          err_total = 0, tests_run = 0, cyc = 0, c0;
  fbsp_top #(.TIMEOUT_CYCLES(4000)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .valley_pulse(valley),
    .ccm_detect(ccm), .flyback_current_sense_pin(sense),
    .vout_meas(vout), .iout_calc(iout), .pout_calc(pout),
    .bus_voltage_sense_pin(vbus), .vbus_aux(vbus),
    .gate_drive(gate_drive), .peak_current_limit(lim),
    .first_valley_mode(fv_mode), .fault_active(fault_active));
  fbsp_stage_model stage_u (.pclk(pclk), .presetn(presetn),
    .gate_drive(gate_drive), .rate(rate), .valley_pulse(valley),
    .flyback_current_sense_pin(sense), .vout_meas(vout));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // reads leave a note {err, mask, data}; writes leave none
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] m = 32'hFFFF_FFFF, input logic e = 1'b0);
    if (!w)
      note_q.push_back({e, m, d & m});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  //////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      nt = note_q.pop_front();
      chk("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
      chk("prdata", nt[31:0], prdata & nt[63:32]);
    end
  // ceiling: startup about 1500 cycles plus a 4000 cycle timeout run
  always @(posedge pclk)
  begin
    rnd  <= lfsr(rnd);
    iout <= rnd & 16'h7FFF;
    pout <= {1'b0, rnd[15:1]};
    cyc++;
    if (cyc > 30000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, ccm} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    vbus = 16'h0100;
    rate = 16'h0020;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CS_CFG, 32'h0100_FFFF);
    apb(0, ADDR_VOUT_CFG, 32'hFFFF_0000);
    apb(0, 12'h044, 32'h0010_0000);
    apb(0, 12'h030, 32'h0, 32'hFFFF_FFFF, 1'b1);
    apb(1, ADDR_SS_CFG, 32'hFFFF_0003);
    apb(1, ADDR_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    apb(0, ADDR_STATUS, 32'h1, 32'h7);
    chk("gate idle", 32'h0, {31'h0, gate_drive});
    vbus <= 16'h0500;
    @(posedge pclk iff lim !== 16'h0);
    chk("first step", 32'h0100, {16'h0, lim});
    for (int k = 0; k < 7; k++)
    begin
      prv = lim;
      @(posedge pclk iff lim !== prv);
      chk("step", {16'h0, prv + 16'h0100}, {16'h0, lim});
    end
    apb(0, ADDR_STATUS, 32'h3, 32'h7);
    @(posedge pclk iff vout >= 16'h0400);
    repeat (4) @(posedge pclk);
    apb(0, ADDR_STATUS, 32'h4, 32'h67);
    chk("loop start", 32'h0100, {16'h0, lim});
    // short dcm wait restarts switching, demand above floor selects qr
    apb(1, ADDR_DEMAND, 32'h0004_0300);
    @(posedge pclk iff valley === 1'b1);
    @(posedge pclk);
    chk("qr mode", 32'h1_0300, {15'h0, fv_mode, lim});
    chk("valley on", 32'h1, {31'h0, gate_drive});
    apb(1, ADDR_VOUT_CFG, 32'h0200_0000);
    repeat (2) @(posedge pclk);
    chk("blanked", 32'h0, {31'h0, fault_active});
    @(posedge pclk);
    chk("tripped", 32'h1, {31'h0, fault_active});
    chk("gate off", 32'h0, {31'h0, gate_drive});
    apb(0, ADDR_FAULT, 32'h4);
    apb(1, ADDR_CTRL, 32'h0);
    apb(1, ADDR_VOUT_CFG, 32'hFFFF_0000);
    apb(1, ADDR_FAULT, 32'hFF);
    apb(0, ADDR_FAULT, 32'h0);
    apb(1, ADDR_CTRL, 32'h1);
    repeat (60) @(posedge pclk);
    ccm <= 1'b1;
    repeat (18) @(posedge pclk);
    chk("ccm blanked", 32'h0, {31'h0, fault_active});
    @(posedge pclk);
    chk("ccm trip", 32'h1, {31'h0, fault_active});
    apb(0, ADDR_FAULT, 32'h40);
    apb(1, ADDR_CTRL, 32'h0);
    apb(1, ADDR_FAULT, 32'hFF);
    // ccm stays high: it must not be checked during startup
    rate <= 16'h0;
    apb(1, ADDR_CTRL, 32'h1);
    c0 = cyc;
    @(posedge pclk iff fault_active === 1'b1);
    chk("timeout", 32'h1, {31'h0, (cyc - c0) inside {[4000:4012]}});
    apb(0, ADDR_FAULT, 32'h2);
    finish_test();
  end
endmodule : test_flyback_mode_startup_protection
`default_nettype wire
